// ==== radio_config_register_bank_tb.sv ====
// Self-checking bench for the radio configuration register bank
`timescale 1ns/1ns
module radio_config_register_bank_tb;
	import rcrb_pkg::*;
	logic       mclk;      // System clock
	logic       rst_b;     // Reset, active low
	logic       sck;       // Serial clock
	logic       csn_b;     // Chip select, active low
	logic       mosi;      // Serial data in
	logic       miso;      // Serial data out
	logic       miso_oe;   // Data out enable
	logic       irq_b;     // Interrupt, active low
	logic [2:0] ev;        // Events: rx, tx, retry
	rcrb_cfg_t  cfg;       // Configuration outputs
	logic [7:0] lfsr;      // Random source
	logic [7:0] st;        // Status byte seen
	logic [7:0] rdv;       // Read data seen
	logic [7:0] sc;        // Shadow configuration
	logic [7:0] sa;        // Shadow auto acknowledge
	logic [7:0] sp;        // Shadow pipe enables
	int         err_total; // Mismatches
	int         n_tests;   // Comparisons

	rcrb_top DUT (.mclk(mclk), .rst_b(rst_b), .sck(sck), .csn_b(csn_b), .mosi(mosi),
		.rx_ready_event(ev[2]), .tx_sent_event(ev[1]), .retry_limit_event(ev[0]),
		.miso(miso), .miso_oe(miso_oe), .irq_b(irq_b), .cfg(cfg));
	rcrb_host_model host (.mclk(mclk), .miso(miso), .sck(sck), .csn_b(csn_b), .mosi(mosi));

	always #10 mclk = ~mclk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Readback: top bit empty, checksum forced by any auto ack
	function automatic logic [7:0] cfg_rd(input logic [7:0] c, input logic [7:0] a);
		return {1'b0, c[6:4], c[3] | (|a[5:0]), c[2:0]};
	endfunction

	function automatic rcrb_cfg_t cfg_exp(input logic [7:0] c, input logic [7:0] a, input logic [7:0] p);
		return {c[1], c[0], c[3] | (|a[5:0]), c[2], a[5:0], p[5:0]};
	endfunction

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host.xfer({3'b001, a}, d, st, rdv);
	endtask

	task automatic rd(input logic [4:0] a);
		host.xfer({3'b000, a}, 8'h00, st, rdv);
	endtask

	// One cycle event pulse, then let the pin settle
	task automatic pulse(input int i);
		@(negedge mclk);
		ev[i] = 1'b1;
		@(negedge mclk);
		ev[i] = 1'b0;
		repeat (3) @(negedge mclk);
	endtask

	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#1000000;
		err_total++;
		conclude();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		mclk      = 1'b0;
		rst_b     = 1'b0;
		ev        = 3'b000;
		err_total = 0;
		n_tests   = 0;
		lfsr      = 8'h1e;
		sc        = RCRB_CONFIG_RESET;
		sa        = RCRB_ACK_RESET;
		sp        = RCRB_PIPE_RESET;
		repeat (12) @(negedge mclk);
		check("irq_b in reset", 16'(irq_b), 16'h0001);
		check("cfg in reset", 16'(cfg), 16'h0000);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		check("cfg after reset", 16'(cfg), 16'(cfg_exp(8'h08, 8'h3f, 8'h03)));
		check("miso_oe idle", 16'(miso_oe), 16'h0000);
		rd(RCRB_MAIN_CONFIGURATION);
		check("config reset", 16'(rdv), 16'h0008);
		rd(RCRB_AUTO_ACKNOWLEDGE_ENABLE);
		check("ack reset", 16'(rdv), 16'h003f);
		rd(RCRB_RECEIVE_PIPE_ENABLE);
		check("pipe reset", 16'(rdv), 16'h0003);
		check("status reset", 16'(st), 16'h0000);
		$display("Test reset values done");

		// Random settings; every third round auto ack off
		for (int i = 0; i < 12; i++) begin
			lfsr = nxt(lfsr);
			sc   = lfsr;
			lfsr = nxt(lfsr);
			sa   = (i % 3 == 0) ? 8'h00 : (lfsr & 8'h3f);
			lfsr = nxt(lfsr);
			sp   = lfsr & 8'h3f;
			wr(RCRB_MAIN_CONFIGURATION, sc);
			wr(RCRB_AUTO_ACKNOWLEDGE_ENABLE, sa);
			wr(RCRB_RECEIVE_PIPE_ENABLE, lfsr);
			rd(RCRB_MAIN_CONFIGURATION);
			check("config", 16'(rdv), 16'(cfg_rd(sc, sa)));
			rd(RCRB_AUTO_ACKNOWLEDGE_ENABLE);
			check("ack", 16'(rdv), 16'(sa));
			rd(RCRB_RECEIVE_PIPE_ENABLE);
			check("pipe", 16'(rdv), 16'(sp));
			check("cfg", 16'(cfg), 16'(cfg_exp(sc, sa, sp)));
		end
		$display("Test random configuration done");

		rd(5'h05);
		check("unmapped", 16'(rdv), 16'h0000);
		wr(RCRB_TEST_FIRST, 8'hff);
		rd(RCRB_TEST_FIRST);
		check("test range", 16'(rdv), 16'h0000);
		$display("Test unmapped done");

		// Each source: unmasked, cleared, then masked
		for (int i = 0; i < 3; i++) begin
			wr(RCRB_MAIN_CONFIGURATION, 8'h0a);
			pulse(i);
			check("irq asserted", 16'(irq_b), 16'h0000);
			rd(RCRB_EVENT_STATUS);
			check("status flag", 16'(st), 16'(8'h01 << (4 + i)));
			wr(RCRB_EVENT_STATUS, 8'h01 << (4 + i));
			check("irq released", 16'(irq_b), 16'h0001);
			// Event lands in the very cycle its clear is written: the event wins
			fork
				wr(RCRB_EVENT_STATUS, 8'h01 << (4 + i));
				begin
					repeat (16) @(posedge sck);
					check("miso_oe framed", 16'(miso_oe), 16'h0001);
					repeat (3) @(negedge mclk);
					ev[i] = 1'b1;
					@(negedge mclk);
					ev[i] = 1'b0;
				end
			join
			check("irq set wins", 16'(irq_b), 16'h0000);
			wr(RCRB_EVENT_STATUS, 8'h01 << (4 + i));
			wr(RCRB_MAIN_CONFIGURATION, 8'h0a | (8'h01 << (4 + i)));
			check("status cleared", 16'(st), 16'h0000);
			pulse(i);
			check("irq masked", 16'(irq_b), 16'h0001);
			wr(RCRB_EVENT_STATUS, 8'h01 << (4 + i));
		end
		$display("Test interrupts done");
		conclude();
	end
endmodule

// ==== rcrb_host_model.sv ====
// Host controller model driving the serial register link
`timescale 1ns/1ns
module rcrb_host_model
	import rcrb_pkg::*;
(
	input  wire logic mclk,  // System clock
	input  wire logic miso,  // Serial data from device
	output logic      sck,   // Serial clock, idle low
	output logic      csn_b, // Chip select, active low
	output logic      mosi   // Serial data to device
);
	logic last_bit; // Last bit sent, inverted while idle

	initial begin
		sck      = 1'b0;
		csn_b    = 1'b1;
		mosi     = 1'b1;
		last_bit = 1'b0;
	end

	// One byte, MSB first, mode 0, sck low five and high four clocks
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			@(negedge mclk);
			mosi     = tx[i];
			last_bit = tx[i];
			repeat (4) @(negedge mclk);
			rx[i] = miso;
			sck   = 1'b1;
			repeat (4) @(negedge mclk);
			sck = 1'b0;
		end
	endtask

	// One framed command plus one data byte
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
		output logic [7:0] st, output logic [7:0] rd);
		logic [7:0] c; // Command actually sent
		logic [7:0] d; // Data actually sent
		c = cmd;
		d = dat;
		if (c[4:0] == RCRB_AUTO_ACKNOWLEDGE_ENABLE || c[4:0] == RCRB_RECEIVE_PIPE_ENABLE) begin
			d[7:6] = 2'b00;
		end
		if (c[4:0] >= RCRB_TEST_FIRST && c[4:0] <= RCRB_TEST_LAST) begin
			c[5] = 1'b0;
		end
		@(negedge mclk);
		csn_b = 1'b0;
		shift_byte(c, st);
		shift_byte(d, rd);
		repeat (4) @(negedge mclk);
		csn_b = 1'b1;
		mosi  = ~last_bit;
		repeat (6) @(negedge mclk);
	endtask
endmodule

// ==== rcrb_pkg.sv ====
// Shared constants and types for the radio configuration register bank
package rcrb_pkg;
	// ----------------------------------------------------------------
	// Command byte layout
	// ----------------------------------------------------------------
	localparam int        RCRB_CMD_WRITE_BIT = 5;      // Set for a register write
	localparam logic [7:0] RCRB_CMD_OP_MASK  = 8'hc0;  // Must be zero for register access
	localparam int        RCRB_ADDR_W        = 5;      // Register address width

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] RCRB_MAIN_CONFIGURATION      = 5'h00;
	localparam logic [4:0] RCRB_AUTO_ACKNOWLEDGE_ENABLE = 5'h01;
	localparam logic [4:0] RCRB_RECEIVE_PIPE_ENABLE     = 5'h02;
	localparam logic [4:0] RCRB_EVENT_STATUS            = 5'h07;
	localparam logic [4:0] RCRB_TEST_FIRST              = 5'h18; // Reserved test range start
	localparam logic [4:0] RCRB_TEST_LAST               = 5'h1b; // Reserved test range end

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RCRB_RX_READY_BIT  = 6; // Receive ready mask and flag
	localparam int RCRB_TX_SENT_BIT   = 5; // Transmit sent mask and flag
	localparam int RCRB_RETRY_BIT     = 4; // Retry limit mask and flag
	localparam int RCRB_CRC_EN_BIT    = 3; // Checksum enable
	localparam int RCRB_CRC_LEN_BIT   = 2; // Checksum length select
	localparam int RCRB_POWER_BIT     = 1; // Power on control
	localparam int RCRB_ROLE_BIT      = 0; // Primary role select
	localparam int RCRB_PIPES         = 6; // Data pipes

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RCRB_CONFIG_RESET = 8'h08; // Checksum enabled, all else zero
	localparam logic [7:0] RCRB_ACK_RESET    = 8'h3f; // All pipes auto acknowledge
	localparam logic [7:0] RCRB_PIPE_RESET   = 8'h03; // Pipes 0 and 1 receive
	localparam logic [7:0] RCRB_STATUS_RESET = 8'h00; // No events pending

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       power_on_control;       // Radio powered up
		logic       primary_role_select;    // 1 receiver, 0 transmitter
		logic       checksum_enable;        // Effective checksum enable
		logic       checksum_length_select; // 1 two bytes, 0 one byte
		logic [5:0] auto_acknowledge_enable; // Per pipe auto acknowledge
		logic [5:0] receive_pipe_enable;    // Per pipe receive enable
	} rcrb_cfg_t;

	typedef enum logic [2:0] {
		RCRB_IDLE,  // No frame
		RCRB_CMD,   // Command byte shifting
		RCRB_READ,  // Returning register contents
		RCRB_WRITE, // Collecting write data
		RCRB_DONE   // Extra bytes ignored
	} rcrb_phase_t;
endpackage

// ==== rcrb_spi_engine.sv ====
// Serial byte engine: pin synchronisers, byte shifting in and out
`timescale 1ns/1ns
module rcrb_spi_engine
	import rcrb_pkg::*;
(
	input  wire logic       mclk,        // System clock
	input  wire logic       rst_b,       // Async reset, active low
	input  wire logic       sck,         // Serial clock pin
	input  wire logic       csn_b,       // Chip select pin, active low
	input  wire logic       mosi,        // Serial data in pin
	input  wire logic [7:0] tx_byte,     // Next byte to send
	output logic            miso,        // Serial data out
	output logic            miso_oe,     // Drive enable for data out
	output logic            frame_start, // Pulse at select assertion
	output logic            frame_on,    // Select held
	output logic            byte_valid,  // Pulse when a byte is in
	output logic [7:0]      rx_byte      // Received byte
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pin_raw;   // Raw pins
	logic [2:0] pin_meta;  // First stage
	logic [2:0] pin_sync;  // Second stage
	logic       sck_prev;  // Previous synced clock
	logic       csn_prev;  // Previous synced select
	logic [2:0] bit_cnt;   // Bits in current byte
	logic [7:0] in_shift;  // Input shifter
	logic [7:0] out_shift; // Output shifter

	assign pin_raw = {sck, csn_b, mosi};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			// Two stage synchroniser per pin
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					pin_meta[gi] <= (gi == 1) ? 1'b1 : 1'b0;
					pin_sync[gi] <= (gi == 1) ? 1'b1 : 1'b0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	wire sck_s  = pin_sync[2];
	wire csn_s  = pin_sync[1];
	wire mosi_s = pin_sync[0];
	wire rise   = sck_s & ~sck_prev & ~csn_s;
	wire fall   = ~sck_s & sck_prev & ~csn_s;

	// ----------------------------------------------------------------
	// Edge history and frame tracking
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sck_prev    <= 1'b0;
			csn_prev    <= 1'b1;
			frame_start <= 1'b0;
			frame_on    <= 1'b0;
		end else begin
			sck_prev    <= sck_s;
			csn_prev    <= csn_s;
			frame_start <= csn_prev & ~csn_s;
			frame_on    <= ~csn_s;
		end
	end

	// ----------------------------------------------------------------
	// Receive shifting on rising serial clock
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt    <= 3'h0;
			in_shift   <= 8'h00;
			rx_byte    <= 8'h00;
			byte_valid <= 1'b0;
		end else begin
			byte_valid <= 1'b0;
			if (csn_s) begin
				bit_cnt <= 3'h0; // Frame end drops partial byte
			end else if (rise) begin
				in_shift <= {in_shift[6:0], mosi_s};
				bit_cnt  <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					rx_byte    <= {in_shift[6:0], mosi_s};
					byte_valid <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit shifting on falling serial clock, MSB first
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			miso      <= 1'b0;
			miso_oe   <= 1'b0;
			out_shift <= 8'h00;
		end else begin
			miso_oe <= ~csn_s;
			if (csn_s) begin
				miso <= 1'b0;
			end else if ((csn_prev & ~csn_s) || (fall && bit_cnt == 3'h0)) begin
				miso      <= tx_byte[7]; // Byte boundary loads next byte
				out_shift <= {tx_byte[6:0], 1'b0};
			end else if (fall) begin
				miso      <= out_shift[7];
				out_shift <= {out_shift[6:0], 1'b0};
			end
		end
	end
endmodule

// ==== rcrb_top.sv ====
// Radio configuration register bank reached over the serial pins
//
// Functional notes
// - Host reaches registers only by serial commands
// - Undefined bits always read as zero
// - Bit 6 masks receive ready interrupt
// - Bit 5 masks transmit sent interrupt
// - Bit 4 masks retry limit interrupt
// - Checksum enable forced by auto acknowledge
// - Bit 1 powers radio, resets down
// - Per pipe auto acknowledge, reset one
// - Interrupt pin low while an unmasked flag stands, until host clears or masks it
`timescale 1ns/1ns
module rcrb_top
	import rcrb_pkg::*;
(
	input  wire logic  mclk,              // System clock, 50 MHz
	input  wire logic  rst_b,             // Async reset, active low
	input  wire logic  sck,               // Serial clock pin
	input  wire logic  csn_b,             // Chip select pin, active low
	input  wire logic  mosi,              // Serial data in pin
	input  wire logic  rx_ready_event,    // Engine: payload received
	input  wire logic  tx_sent_event,     // Engine: payload sent
	input  wire logic  retry_limit_event, // Engine: retries exhausted
	output logic       miso,              // Serial data out
	output logic       miso_oe,           // Drive enable for data out
	output logic       irq_b,             // Interrupt pin, active low
	output rcrb_cfg_t  cfg                // Configuration to the radio
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic        frame_start;  // Select asserted pulse
	logic        frame_on;     // Select held
	logic        byte_valid;   // Byte received pulse
	logic [7:0]  rx_byte;      // Received byte
	logic [7:0]  tx_byte;      // Byte to shift out next
	rcrb_phase_t phase;        // Frame phase
	logic [4:0]  addr;         // Addressed register
	logic [6:0]  config_reg;   // Main configuration, bit 7 not held
	logic [5:0]  ack_reg;      // Auto acknowledge enables
	logic [5:0]  pipe_reg;     // Receive pipe enables
	logic [6:4]  flags;        // Sticky event flags
	logic [7:0]  status_byte;  // Status as read
	logic [7:0]  read_value;   // Addressed register as read
	logic        wr_strobe;    // Write data accepted
	logic [6:4]  flag_clear;   // Write one to clear
	logic [6:4]  flag_set;     // Engine events

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	rcrb_spi_engine u_engine (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.sck         (sck),
		.csn_b       (csn_b),
		.mosi        (mosi),
		.tx_byte     (tx_byte),
		.miso        (miso),
		.miso_oe     (miso_oe),
		.frame_start (frame_start),
		.frame_on    (frame_on),
		.byte_valid  (byte_valid),
		.rx_byte     (rx_byte)
	);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Frame phase: command byte, then one data byte
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= RCRB_IDLE;
			addr  <= 5'h00;
		end else if (!frame_on) begin
			phase <= RCRB_IDLE;
		end else begin
			case (phase)
				RCRB_IDLE: begin
					if (frame_start) begin
						phase <= RCRB_CMD;
					end
				end
				RCRB_CMD: begin
					if (byte_valid) begin
						addr <= rx_byte[RCRB_ADDR_W-1:0];
						if ((rx_byte & RCRB_CMD_OP_MASK) != 8'h00) begin
							phase <= RCRB_DONE; // Other commands ignored
						end else if (rx_byte[RCRB_CMD_WRITE_BIT]) begin
							phase <= RCRB_WRITE;
						end else begin
							phase <= RCRB_READ;
						end
					end
				end
				RCRB_READ, RCRB_WRITE: begin
					if (byte_valid) begin
						phase <= RCRB_DONE;
					end
				end
				RCRB_DONE: begin
					phase <= RCRB_DONE;
				end
				default: begin
					phase <= RCRB_IDLE;
				end
			endcase
		end
	end

	assign wr_strobe  = (phase == RCRB_WRITE) && byte_valid;
	assign status_byte = {1'b0, flags, 4'h0};

	// Read mux, undefined bits zero
	always_comb begin
		read_value = 8'h00;
		case (addr)
			RCRB_MAIN_CONFIGURATION: begin
				read_value = {1'b0, config_reg};
				read_value[RCRB_CRC_EN_BIT] = config_reg[RCRB_CRC_EN_BIT] | (|ack_reg);
			end
			RCRB_AUTO_ACKNOWLEDGE_ENABLE: begin
				read_value = {2'b00, ack_reg};
			end
			RCRB_RECEIVE_PIPE_ENABLE: begin
				read_value = {2'b00, pipe_reg};
			end
			RCRB_EVENT_STATUS: begin
				read_value = status_byte;
			end
			default: begin
				read_value = 8'h00;
			end
		endcase
	end

	// Status during command, register during read, else zero
	always_comb begin
		case (phase)
			RCRB_IDLE, RCRB_CMD: begin
				tx_byte = status_byte;
			end
			RCRB_READ: begin
				tx_byte = read_value;
			end
			default: begin
				tx_byte = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Writable fields; reserved bits dropped
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			config_reg <= RCRB_CONFIG_RESET[6:0];
			ack_reg    <= RCRB_ACK_RESET[5:0];
			pipe_reg   <= RCRB_PIPE_RESET[5:0];
		end else if (wr_strobe) begin
			case (addr)
				RCRB_MAIN_CONFIGURATION: begin
					config_reg <= rx_byte[6:0];
				end
				RCRB_AUTO_ACKNOWLEDGE_ENABLE: begin
					ack_reg <= rx_byte[5:0];
				end
				RCRB_RECEIVE_PIPE_ENABLE: begin
					pipe_reg <= rx_byte[5:0];
				end
				default: begin
					ack_reg <= ack_reg; // Test range and unmapped ignored
				end
			endcase
		end
	end

	// Registered copy to the radio
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= '0;
		end else begin
			cfg.power_on_control        <= config_reg[RCRB_POWER_BIT];
			cfg.primary_role_select     <= config_reg[RCRB_ROLE_BIT];
			cfg.checksum_enable         <= config_reg[RCRB_CRC_EN_BIT] | (|ack_reg);
			cfg.checksum_length_select  <= config_reg[RCRB_CRC_LEN_BIT];
			cfg.auto_acknowledge_enable <= ack_reg;
			cfg.receive_pipe_enable     <= pipe_reg;
		end
	end

	// ----------------------------------------------------------------
	// Event flags and interrupt pin
	// ----------------------------------------------------------------
	assign flag_set   = {rx_ready_event, tx_sent_event, retry_limit_event};
	assign flag_clear = (wr_strobe && addr == RCRB_EVENT_STATUS) ? rx_byte[6:4] : 3'h0;

	// Sticky flags, set wins over clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flags <= RCRB_STATUS_RESET[6:4];
		end else begin
			flags <= (flags & ~flag_clear) | flag_set;
		end
	end

	// Pin low while any unmasked flag stands
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_b <= 1'b1;
		end else begin
			irq_b <= ~|(flags & ~config_reg[6:4]);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	rx_ready_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(flags[6] && !config_reg[6]) |=> !irq_b)
		else $error("Unmasked receive ready flag did not pull pin low");
	masked_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
		((flags & ~config_reg[6:4]) == 3'b000) |=> irq_b)
		else $error("Interrupt asserted with no unmasked source");
	tx_sent_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(flags[5] && !config_reg[5]) |=> !irq_b)
		else $error("Unmasked transmit sent flag did not pull pin low");
	retry_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(flags[4] && !config_reg[4]) |=> !irq_b)
		else $error("Unmasked retry flag did not pull pin low");
	crc_forced_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(|ack_reg) |=> cfg.checksum_enable)
		else $error("Checksum enable not forced by auto acknowledge");
	power_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_strobe && addr == RCRB_MAIN_CONFIGURATION) |=> ##1 (cfg.power_on_control == $past(rx_byte[1], 2)))
		else $error("Power control did not follow write");
	role_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_strobe && addr == RCRB_MAIN_CONFIGURATION) |=> ##1 (cfg.primary_role_select == $past(rx_byte[0], 2)))
		else $error("Role select did not follow write");
	ack_reserved_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(phase == RCRB_READ && addr == RCRB_AUTO_ACKNOWLEDGE_ENABLE) |-> (tx_byte[7:6] == 2'b00))
		else $error("Reserved acknowledge bits read non zero");
	pipe_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_strobe && addr == RCRB_RECEIVE_PIPE_ENABLE) |=> ##1 (cfg.receive_pipe_enable == $past(rx_byte[5:0], 2)))
		else $error("Pipe enables did not follow write");
	set_wins_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(rx_ready_event && flag_clear[6]) |=> flags[6] ##1 (!irq_b || config_reg[6]))
		else $error("Event lost against a clear");
	clear_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(flags == 3'b100 && flag_clear == 3'b100 && flag_set == 3'b000) |=> (flags == 3'b000) ##1 irq_b)
		else $error("Pin not released after clear");
endmodule
